// ===== pei_pkg.sv
package pei_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_MHZ  = 10;
  localparam int unsigned DEB_TIME_NS   = 20000;    // 20 us filter window
  localparam int unsigned SC_WAIT_NS    = 1000000;  // 1 ms start-up check
  localparam int unsigned OVL_TIME_NS   = 1000000;  // 1 ms overload window
  localparam int unsigned DEB_CYCLES    = (DEB_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned SC_CYCLES     = (SC_WAIT_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned OVL_CYCLES    = (OVL_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned CNT_W         = 14;
  localparam int unsigned NUM_PHASES    = 4;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  ADDR_FLAGS    = 8'h00;
  localparam logic [7:0]  ADDR_MASK     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_CTRL     = 8'h0c;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Flag, mask and live status bit positions
  localparam int unsigned FLAG_W        = 12;
  localparam int unsigned F_RESET       = 0;
  localparam int unsigned F_HOT_WARN    = 1;
  localparam int unsigned F_OVERHEAT    = 2;
  localparam int unsigned F_LOAD_READY  = 3;
  localparam int unsigned F_SHORT       = 4;
  localparam int unsigned F_OUT_GOOD    = 5;
  localparam int unsigned S_RUNNING     = 6;
  localparam int unsigned F_PEAK_LO     = 8;
  localparam int unsigned SUMMARY_LO    = 16;
  localparam int unsigned S_STANDBY     = 12;
  localparam logic [FLAG_W-1:0] MASKABLE = 12'hf2b;

  // Control register bit positions
  localparam int unsigned C_EN_REG      = 0;
  localparam int unsigned C_PIN_CTRL    = 1;
  localparam int unsigned C_PIN_SEL     = 2;
  localparam int unsigned C_THR_SEL     = 3;
  localparam int unsigned C_RDIS_LO     = 4;
  localparam int unsigned C_SOFT_RST    = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pei_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pei_axi_rsp_t;

  typedef struct packed {
    logic [NUM_PHASES-1:0] peak_limit_raw;
    logic                  out_below_thr;
    logic                  hot_warn_lo;
    logic                  hot_warn_hi;
    logic                  overheat;
    logic                  out_good;
    logic                  meas_done;
    logic                  en1;
    logic                  en2;
  } pei_sense_t;

  typedef struct packed {
    logic                  regulator_enable;
    logic                  switches_hiz;
    logic [NUM_PHASES-1:0] discharge_on;
    logic                  device_standby;
  } pei_drive_t;

  typedef struct packed {
    logic [FLAG_W-1:0]     flag;
    logic [FLAG_W-1:0]     mask;
    logic                  en_reg;
    logic                  pin_ctrl;
    logic                  pin_sel;
    logic                  hot_warning_threshold_sel;
    logic [NUM_PHASES-1:0] discharge_pulldown_enable;
  } pei_regs_t;

  localparam pei_regs_t REGS_RST = '{flag: 12'h001, default: '0};

  typedef enum logic [1:0] {
    PEI_REG_OFF   = 2'b00,
    PEI_REG_START = 2'b01,
    PEI_REG_RUN   = 2'b10
  } pei_reg_state_t;

  typedef struct packed {
    pei_sense_t        sync1;
    pei_sense_t        sync2;
    logic              pg_prev;
    logic              meas_prev;
    pei_reg_state_t    rstate;
    logic [CNT_W-1:0]  start_cnt;
    logic              prot_off;
    pei_regs_t         regs;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] wa;
    logic [31:0]       wd;
    logic [3:0]        ws;
    pei_axi_rsp_t      rsp;
    pei_drive_t        drv;
    logic              irq_out_n;
  } pei_state_t;

endpackage

// ===== pei_debounce.sv
`timescale 1ns/1ps

// Takes a level only after it has differed from the output for COUNT cycles
module pei_debounce #(
  parameter int unsigned COUNT = pei_pkg::DEB_CYCLES,
  parameter int unsigned CNT_W = pei_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Levels
  input  wire logic level_in,
  output logic      level_out
);
  import pei_pkg::*;

  typedef struct packed {
    logic             level;
    logic [CNT_W-1:0] cnt;
  } pei_deb_state_t;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(COUNT - 1);

  pei_deb_state_t s;
  pei_deb_state_t next_s;

  // Count disagreement, flip at the end of the window
  always_comb begin
    next_s = s;
    if (level_in == s.level) begin
      next_s.cnt = '0;
    end else if (s.cnt == LAST) begin
      next_s.level = level_in;
      next_s.cnt   = '0;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level_out = s.level;

endmodule // pei_debounce

// ===== pei_protection_event_irq_logic.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

module pei_protection_event_irq_logic #(
  parameter int unsigned SC_WAIT_CYCLES  = pei_pkg::SC_CYCLES,
  parameter int unsigned OVERLOAD_CYCLES = pei_pkg::OVL_CYCLES,
  parameter int unsigned FILTER_CYCLES   = pei_pkg::DEB_CYCLES
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Register bus
  input  pei_pkg::pei_axi_req_t axi_req,
  output pei_pkg::pei_axi_rsp_t axi_rsp,
  // Comparators and enable pins
  input  pei_pkg::pei_sense_t   sense_in,
  // Power stage control
  output pei_pkg::pei_drive_t   drive_out,
  // Host interrupt
  output logic                  irq_out_n
);
  import pei_pkg::*;

  localparam logic [CNT_W-1:0] SC_LAST = CNT_W'(SC_WAIT_CYCLES - 1);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Byte enables widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Byte-wise merge of written data into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    return (old & ~strb_mask(strb)) | (data & strb_mask(strb));
  endfunction

  // Per-phase summary of pending flags
  function automatic logic [NUM_PHASES-1:0] summary(input logic [FLAG_W-1:0] f);
    logic [NUM_PHASES-1:0] v;
    v    = f[F_PEAK_LO +: NUM_PHASES];
    v[0] = v[0] | f[F_SHORT] | f[F_OUT_GOOD];
    return v;
  endfunction

  // ****************************************************************
  // State and filters
  // ****************************************************************
  pei_state_t            s;
  pei_state_t            next_s;
  logic [NUM_PHASES-1:0] peak_limit_live;
  logic                  hot_warning_live;
  logic                  overheat_shutdown_live;
  logic                  output_good_live;
  logic                  overload_low;
  logic                  hot_raw;

  // Warning level chosen by the threshold select bit
  assign hot_raw = s.regs.hot_warning_threshold_sel ? s.sync2.hot_warn_hi
                                                     : s.sync2.hot_warn_lo;

  // Peak limit filters per phase
  for (genvar p = 0; p < NUM_PHASES; p++) begin : g_peak
    pei_debounce #(.COUNT(FILTER_CYCLES), .CNT_W(CNT_W)) u_peak (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .level_in  (s.sync2.peak_limit_raw[p]),
      .level_out (peak_limit_live[p])
    );
  end

  // Hot warning filter
  pei_debounce #(.COUNT(FILTER_CYCLES), .CNT_W(CNT_W)) u_hot (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .level_in  (hot_raw),
    .level_out (hot_warning_live)
  );

  // Overheat filter
  pei_debounce #(.COUNT(FILTER_CYCLES), .CNT_W(CNT_W)) u_overheat (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .level_in  (s.sync2.overheat),
    .level_out (overheat_shutdown_live)
  );

  // Output good filter
  pei_debounce #(.COUNT(FILTER_CYCLES), .CNT_W(CNT_W)) u_good (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .level_in  (s.sync2.out_good),
    .level_out (output_good_live)
  );

  // Overload filter, long window
  pei_debounce #(.COUNT(OVERLOAD_CYCLES), .CNT_W(CNT_W)) u_overload (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .level_in  (s.sync2.out_below_thr),
    .level_out (overload_low)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic              request;
  logic              permit;
  logic              short_evt;
  logic              overheat_trip;
  logic              do_wr;
  logic [31:0]       wr_mask;
  logic [FLAG_W-1:0] set_vec;
  logic [FLAG_W-1:0] hold_vec;
  logic [FLAG_W-1:0] clr_vec;
  logic [31:0]       ctrl_word;
  logic [31:0]       ctrl_new;
  logic [31:0]       mask_new;
  logic [31:0]       rd_word;
  logic              rd_ok;

  always_comb begin
    next_s        = s;
    short_evt     = 1'b0;
    clr_vec       = '0;
    ctrl_new      = '0;
    mask_new      = '0;
    rd_word       = '0;
    rd_ok         = 1'b0;
    do_wr         = s.aw_got && s.w_got;
    wr_mask       = strb_mask(s.ws);

    // Two-stage pin synchronisers
    next_s.sync1     = sense_in;
    next_s.sync2     = s.sync1;
    next_s.pg_prev   = output_good_live;
    next_s.meas_prev = s.sync2.meas_done;

    // Enable request from the control bit, gated by the selected pin when pin control is set
    request = s.regs.en_reg &&
              (!s.regs.pin_ctrl || (s.regs.pin_sel ? s.sync2.en2 : s.sync2.en1));
    permit  = request && !s.regs.flag[F_SHORT] && !s.regs.flag[F_OVERHEAT] &&
              !overheat_shutdown_live;
    overheat_trip = overheat_shutdown_live && (s.rstate != PEI_REG_OFF);

    // Regulator sequencing
    case (s.rstate)
      PEI_REG_OFF: begin
        if (permit) begin
          next_s.rstate    = PEI_REG_START;
          next_s.start_cnt = '0;
          next_s.prot_off  = 1'b0;
        end
      end
      PEI_REG_START: begin
        if (overheat_trip) begin
          next_s.rstate   = PEI_REG_OFF;
          next_s.prot_off = 1'b1;
        end else if (!permit) begin
          next_s.rstate = PEI_REG_OFF;
        end else if (s.start_cnt == SC_LAST) begin
          if (s.sync2.out_below_thr) begin
            short_evt       = 1'b1;
            next_s.rstate   = PEI_REG_OFF;
            next_s.prot_off = 1'b1;
          end else begin
            next_s.rstate = PEI_REG_RUN;
          end
        end else begin
          next_s.start_cnt = s.start_cnt + 1'b1;
        end
      end
      PEI_REG_RUN: begin
        if (overheat_trip) begin
          next_s.rstate   = PEI_REG_OFF;
          next_s.prot_off = 1'b1;
        end else if (overload_low) begin
          short_evt       = 1'b1;
          next_s.rstate   = PEI_REG_OFF;
          next_s.prot_off = 1'b1;
        end else if (!permit) begin
          next_s.rstate = PEI_REG_OFF;
        end
      end
      default: begin
        next_s.rstate = PEI_REG_OFF;
      end
    endcase

    // Flag sources; live-held flags refuse clearing
    set_vec                              = '0;
    set_vec[F_HOT_WARN]                  = hot_warning_live;
    set_vec[F_OVERHEAT]                  = overheat_shutdown_live;
    set_vec[F_LOAD_READY]                = s.sync2.meas_done && !s.meas_prev;
    set_vec[F_SHORT]                     = short_evt;
    set_vec[F_OUT_GOOD]                  = output_good_live && !s.pg_prev;
    set_vec[F_PEAK_LO +: NUM_PHASES]     = peak_limit_live;
    hold_vec                             = '0;
    hold_vec[F_OVERHEAT]                 = overheat_shutdown_live;
    hold_vec[F_PEAK_LO +: NUM_PHASES]    = peak_limit_live;

    // Register writes
    ctrl_word = '0;
    ctrl_word[C_EN_REG]                  = s.regs.en_reg;
    ctrl_word[C_PIN_CTRL]                = s.regs.pin_ctrl;
    ctrl_word[C_PIN_SEL]                 = s.regs.pin_sel;
    ctrl_word[C_THR_SEL]                 = s.regs.hot_warning_threshold_sel;
    ctrl_word[C_RDIS_LO +: NUM_PHASES]   = s.regs.discharge_pulldown_enable;
    if (do_wr) begin
      next_s.aw_got     = 1'b0;
      next_s.w_got      = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = RESP_OKAY;
      if (s.wa == ADDR_FLAGS) begin
        clr_vec = s.wd[FLAG_W-1:0] & wr_mask[FLAG_W-1:0] & ~hold_vec;
      end else if (s.wa == ADDR_MASK) begin
        // Merge in a full word first, then keep only the maskable bits
        mask_new         = merge({20'h0, s.regs.mask}, s.wd, s.ws);
        next_s.regs.mask = mask_new[FLAG_W-1:0] & MASKABLE;
      end else if (s.wa == ADDR_CTRL) begin
        ctrl_new = merge(ctrl_word, s.wd, s.ws);
        next_s.regs.en_reg                    = ctrl_new[C_EN_REG];
        next_s.regs.pin_ctrl                  = ctrl_new[C_PIN_CTRL];
        next_s.regs.pin_sel                   = ctrl_new[C_PIN_SEL];
        next_s.regs.hot_warning_threshold_sel = ctrl_new[C_THR_SEL];
        next_s.regs.discharge_pulldown_enable = ctrl_new[C_RDIS_LO +: NUM_PHASES];
      end else if (s.wa == ADDR_STATUS) begin
        next_s.rsp.bresp = RESP_OKAY;
      end else begin
        next_s.rsp.bresp = RESP_SLVERR;
      end
    end

    // Sticky flags, a set beats a clear in the same cycle
    next_s.regs.flag = (s.regs.flag & ~clr_vec) | set_vec;

    // Soft reset restores defaults and raises the reset flag
    if (do_wr && (s.wa == ADDR_CTRL) && ctrl_new[C_SOFT_RST]) begin
      next_s.regs   = REGS_RST;
      next_s.rstate = PEI_REG_OFF;
    end

    // Write address and data channels, either order
    if (axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_got      = 1'b1;
      next_s.wa          = {axi_req.awaddr[ADDR_W-1:2], 2'b00};
      next_s.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.w_got      = 1'b1;
      next_s.wd         = axi_req.wdata;
      next_s.ws         = axi_req.wstrb;
      next_s.rsp.wready = 1'b0;
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid  = 1'b0;
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready  = 1'b1;
    end

    // Read decode
    if ({axi_req.araddr[ADDR_W-1:2], 2'b00} == ADDR_FLAGS) begin
      rd_ok                                 = 1'b1;
      rd_word[FLAG_W-1:0]                   = s.regs.flag;
      rd_word[SUMMARY_LO +: NUM_PHASES]     = summary(s.regs.flag);
    end else if ({axi_req.araddr[ADDR_W-1:2], 2'b00} == ADDR_MASK) begin
      rd_ok                                 = 1'b1;
      rd_word[FLAG_W-1:0]                   = s.regs.mask;
    end else if ({axi_req.araddr[ADDR_W-1:2], 2'b00} == ADDR_STATUS) begin
      rd_ok                                 = 1'b1;
      rd_word[F_HOT_WARN]                   = hot_warning_live;
      rd_word[F_OVERHEAT]                   = overheat_shutdown_live;
      rd_word[F_OUT_GOOD]                   = output_good_live;
      rd_word[S_RUNNING]                    = (s.rstate == PEI_REG_RUN);
      rd_word[F_PEAK_LO +: NUM_PHASES]      = peak_limit_live;
      rd_word[S_STANDBY]                    = s.drv.device_standby;
    end else if ({axi_req.araddr[ADDR_W-1:2], 2'b00} == ADDR_CTRL) begin
      rd_ok                                 = 1'b1;
      rd_word                               = ctrl_word;
    end

    // Read channel
    if (axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid  = 1'b1;
      next_s.rsp.arready = 1'b0;
      next_s.rsp.rdata   = rd_word;
      next_s.rsp.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid  = 1'b0;
      next_s.rsp.arready = 1'b1;
    end

    // Power stage outputs
    next_s.drv.regulator_enable = (next_s.rstate != PEI_REG_OFF);
    next_s.drv.switches_hiz     = (next_s.rstate == PEI_REG_OFF);
    next_s.drv.device_standby   = (next_s.rstate == PEI_REG_OFF);
    next_s.drv.discharge_on     = (next_s.rstate == PEI_REG_OFF) && next_s.prot_off ?
                                  next_s.regs.discharge_pulldown_enable : '0;

    // Interrupt line from unmasked pending flags
    next_s.irq_out_n = ~|(s.regs.flag & ~s.regs.mask);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s                    <= '0;
      s.regs               <= REGS_RST;
      s.rstate             <= PEI_REG_OFF;
      s.rsp.awready        <= 1'b1;
      s.rsp.wready         <= 1'b1;
      s.rsp.arready        <= 1'b1;
      s.drv.switches_hiz   <= 1'b1;
      s.drv.device_standby <= 1'b1;
      s.irq_out_n          <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Ports straight from the state register
  assign axi_rsp   = s.rsp;
  assign drive_out = s.drv;
  assign irq_out_n = s.irq_out_n;

endmodule // pei_protection_event_irq_logic

// ===== pei_chk.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module pei_chk
  import pei_pkg::*;
#(
  parameter int unsigned SC_WAIT_CYCLES  = pei_pkg::SC_CYCLES,
  parameter int unsigned OVERLOAD_CYCLES = pei_pkg::OVL_CYCLES,
  parameter int unsigned FILTER_CYCLES   = pei_pkg::DEB_CYCLES
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Watched ports
  input pei_pkg::pei_axi_req_t  axi_req,
  input pei_pkg::pei_axi_rsp_t  axi_rsp,
  input pei_pkg::pei_sense_t    sense_in,
  input pei_pkg::pei_drive_t    drive_out,
  input wire logic              irq_out_n
);
  logic [15:0] hot_cnt;
  logic [15:0] low_cnt;
  // Run lengths of overheat and of a low output while driven
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hot_cnt <= '0;
      low_cnt <= '0;
    end else begin
      hot_cnt <= sense_in.overheat ? hot_cnt + {15'h0, ~&hot_cnt} : '0;
      low_cnt <= (sense_in.out_below_thr && drive_out.regulator_enable) ? low_cnt + 16'h1 : '0;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_irq_hi_rst: assert property ($rose(aresetn) |-> irq_out_n)
    else $error("interrupt low at reset release");
  a_irq_lo_rst: assert property ($rose(aresetn) |-> ##[1:3] !irq_out_n)
    else $error("reset flag did not raise interrupt");
  a_irq_rel_wr: assert property ($rose(irq_out_n) |-> $past(axi_rsp.bvalid))
    else $error("interrupt released without a write");
  a_hiz_off: assert property (!drive_out.regulator_enable |-> drive_out.switches_hiz)
    else $error("switches driven while off");
  a_pull_off: assert property (|drive_out.discharge_on |-> !drive_out.regulator_enable)
    else $error("pulldown while running");
  a_hot_stop: assert property (hot_cnt > FILTER_CYCLES + 6 |->
    !drive_out.regulator_enable && drive_out.device_standby)
    else $error("overheat did not stop regulator");
  a_low_cut: assert property (low_cnt <= SC_WAIT_CYCLES + OVERLOAD_CYCLES + 4)
    else $error("low output not cut off");
  a_rd_ans: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read not answered");
  a_wr_ans: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid)
    else $error("write not answered");
  c_prot: cover property ($fell(drive_out.regulator_enable));
  c_rel: cover property ($rose(irq_out_n));
  c_hot: cover property (hot_cnt > FILTER_CYCLES + 6);
endmodule // pei_chk

bind pei_protection_event_irq_logic pei_chk #(.SC_WAIT_CYCLES(SC_WAIT_CYCLES),
  .OVERLOAD_CYCLES(OVERLOAD_CYCLES), .FILTER_CYCLES(FILTER_CYCLES)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .sense_in(sense_in), .drive_out(drive_out), .irq_out_n(irq_out_n));

// ===== pei_host_model.sv
`timescale 1ns/1ps
// ****
// Host bus master
// ****
module pei_host_model
  import pei_pkg::*;
(
  // Clock
  input wire logic              aclk,
  // Register bus
  output pei_pkg::pei_axi_req_t axi_req,
  input  pei_pkg::pei_axi_rsp_t axi_rsp
);
  // Idle bus, answers always accepted
  initial begin
    axi_req = '0;
    axi_req.bready = 1'b1;
    axi_req.rready = 1'b1;
  end
  // One write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (axi_rsp.awready && !aw_ok) begin
        aw_ok = 1'b1;
        axi_req.awvalid <= 1'b0;
        axi_req.awaddr <= ~a;
      end
      if (axi_rsp.wready && !w_ok) begin
        w_ok = 1'b1;
        axi_req.wvalid <= 1'b0;
        axi_req.wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!axi_rsp.bvalid);
    r = axi_rsp.bresp;
  endtask
  // One read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    do @(posedge aclk); while (!axi_rsp.arready);
    axi_req.arvalid <= 1'b0;
    axi_req.araddr <= ~a;
    do @(posedge aclk); while (!axi_rsp.rvalid);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
  endtask
endmodule // pei_host_model

// ===== tb.sv
`timescale 1ns/1ps
// ****
// Testbench
// ****
module tb;
  import pei_pkg::*;
  localparam int SCW = 20;
  localparam int OVL = 30;
  localparam int FLT = 4;
  logic         aclk;
  logic         aresetn;
  pei_axi_req_t axi_req;
  pei_axi_rsp_t axi_rsp;
  pei_sense_t   sense_in;
  pei_drive_t   drive_out;
  logic         irq_out_n;
  logic [31:0]  seed;
  logic [31:0]  d;
  logic [31:0]  rd_d;
  logic [1:0]   resp;
  int           num_errors = 0;
  int           checks = 0;
  int           cyc = 0;

  pei_protection_event_irq_logic #(.SC_WAIT_CYCLES(SCW), .OVERLOAD_CYCLES(OVL),
    .FILTER_CYCLES(FLT)) u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .sense_in(sense_in), .drive_out(drive_out), .irq_out_n(irq_out_n));
  pei_host_model u_host (.aclk(aclk), .axi_req(axi_req), .axi_rsp(axi_rsp));

  // Clock and hang limit
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Flag word with its phase summary
  function automatic logic [31:0] fx(input logic [11:0] f);
    logic [3:0] s;
    s = f[11:8];
    s[0] = s[0] | f[F_SHORT] | f[F_OUT_GOOD];
    return {12'h0, s, 4'h0, f};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    u_host.rd(a, rd_d, resp);
    chk(rd_d & m, e);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    u_host.wr(a, v, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 32'd75;
    aresetn = 1'b0;
    sense_in = '0;
    wt(8);
    aresetn <= 1'b1;
    wt(3);
    rchk(ADDR_FLAGS, '1, fx(12'h001));
    chk({31'h0, irq_out_n}, 32'h0);
    u_host.rd(8'h10, rd_d, resp);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    d = xs();
    w(ADDR_MASK, d);
    rchk(ADDR_MASK, '1, {20'h0, d[11:0] & MASKABLE});
    w(ADDR_MASK, 32'h2);
    w(ADDR_FLAGS, 32'h1);
    wt(2);
    chk({31'h0, irq_out_n}, 32'h1);
    $display("test reset done");
    sense_in.hot_warn_lo <= 1'b1;
    wt(FLT + 6);
    rchk(ADDR_STATUS, 32'h2, 32'h2);
    rchk(ADDR_FLAGS, '1, fx(12'h002));
    chk({31'h0, irq_out_n}, 32'h1);
    w(ADDR_MASK, 32'h0);
    wt(2);
    chk({31'h0, irq_out_n}, 32'h0);
    w(ADDR_CTRL, 32'h8);
    wt(FLT + 6);
    w(ADDR_FLAGS, 32'h2);
    rchk(ADDR_FLAGS, '1, fx(12'h000));
    sense_in.hot_warn_lo <= 1'b0;
    $display("test hot done");
    for (int p = 0; p < NUM_PHASES; p++) begin
      sense_in.peak_limit_raw <= 4'(1 << p);
      wt(FLT + 6);
      rchk(ADDR_STATUS, 32'hf00, 32'h100 << p);
      w(ADDR_FLAGS, 32'h100 << p);
      rchk(ADDR_FLAGS, '1, fx(12'h100 << p));
      sense_in.peak_limit_raw <= 4'h0;
      wt(FLT + 6);
      w(ADDR_FLAGS, 32'h100 << p);
      rchk(ADDR_FLAGS, '1, fx(12'h000));
    end
    $display("test peak done");
    d = xs() & 32'hf0;
    sense_in.out_below_thr <= 1'b1;
    w(ADDR_CTRL, d | 32'h1);
    wt(SCW + FLT + 8);
    chk({31'h0, drive_out.regulator_enable}, 32'h0);
    chk({28'h0, drive_out.discharge_on}, {28'h0, d[7:4]});
    rchk(ADDR_FLAGS, '1, fx(12'h010));
    rchk(ADDR_STATUS, 32'h40, 32'h0);
    sense_in.out_below_thr <= 1'b0;
    wt(OVL + 6);
    w(ADDR_FLAGS, 32'h10);
    wt(4);
    chk({31'h0, drive_out.regulator_enable}, 32'h1);
    sense_in.out_good <= 1'b1;
    wt(SCW + FLT + 6);
    rchk(ADDR_STATUS, 32'h60, 32'h60);
    rchk(ADDR_FLAGS, '1, fx(12'h020));
    w(ADDR_FLAGS, 32'h20);
    sense_in.out_below_thr <= 1'b1;
    wt(OVL / 2);
    chk({31'h0, drive_out.regulator_enable}, 32'h1);
    wt(OVL);
    chk({31'h0, drive_out.regulator_enable}, 32'h0);
    rchk(ADDR_FLAGS, '1, fx(12'h010));
    sense_in.out_below_thr <= 1'b0;
    $display("test short done");
    wt(OVL + 6);
    w(ADDR_FLAGS, 32'h10);
    wt(SCW);
    sense_in.overheat <= 1'b1;
    sense_in.meas_done <= 1'b1;
    wt(FLT + 8);
    sense_in.meas_done <= 1'b0;
    chk({31'h0, drive_out.device_standby}, 32'h1);
    w(ADDR_FLAGS, 32'h4);
    rchk(ADDR_FLAGS, '1, fx(12'h00c));
    sense_in.overheat <= 1'b0;
    wt(FLT + 6);
    w(ADDR_FLAGS, 32'h4);
    rchk(ADDR_FLAGS, '1, fx(12'h008));
    w(ADDR_CTRL, 32'h100);
    rchk(ADDR_FLAGS, '1, fx(12'h001));
    rchk(ADDR_CTRL, '1, 32'h0);
    $display("test overheat done");
    sense_in.en1 <= 1'b1;
    w(ADDR_CTRL, 32'hf7);
    wt(4);
    chk({31'h0, drive_out.regulator_enable}, 32'h0);
    sense_in.en2 <= 1'b1;
    wt(6);
    chk({31'h0, drive_out.switches_hiz}, 32'h0);
    rchk(ADDR_STATUS, 32'h1000, 32'h0);
    sense_in.en2 <= 1'b0;
    wt(6);
    chk({27'h0, drive_out.regulator_enable, drive_out.discharge_on}, 32'h0);
    u_host.wr(8'h10, 32'h0, resp);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    $display("test pins done");
    tally_and_finish();
  end
endmodule // tb
